// ==== i2c_control_one_master_start_stop.sv ====
/*
  two-wire bus controller front end: the control one register with its
  enable, interrupt allow, master select and transmit select bits, the
  start/stop sequencer on the open-drain lines, bus condition watch and
  sticky interrupt events.
  assumes a byte register port on core_clk and external pull-ups; the
  testbench resolves each line from the enables.
*/
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "i2c_ctrl_cfg.svh"
module i2c_control_one_master_start_stop (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output      logic [7:0] reg_rdata,
  output      logic       irq,
  input  wire logic       scl_in,
  output      logic       scl_out,
  output      logic       scl_oe,
  input  wire logic       sda_in,
  output      logic       sda_out,
  output      logic       sda_oe,
  output      logic       transmit_dir,
  output      logic       master_active
);

  // register port decode, used by both write and read paths
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
    addr_is = (addr == offset);
  endfunction : addr_is

  // phases that wait out the condition hold time
  function automatic logic is_timed(input i2c_ctrl_pkg::seq_state_t st);
    is_timed = (st == i2c_ctrl_pkg::ST_START_SDA) || (st == i2c_ctrl_pkg::ST_START_SCL) ||
               (st == i2c_ctrl_pkg::ST_STOP_SDA)  || (st == i2c_ctrl_pkg::ST_STOP_SCL);
  endfunction : is_timed

  i2c_ctrl_pkg::line_pair_t   line_raw;
  i2c_ctrl_pkg::line_pair_t   line;
  i2c_ctrl_pkg::line_pair_t   line_prev;
  i2c_ctrl_pkg::line_pair_t   next_line_prev;
  i2c_ctrl_pkg::seq_state_t   state;
  i2c_ctrl_pkg::seq_state_t   next_state;
  logic [7:0]                 control_one;
  logic [7:0]                 next_control_one;
  logic [`EV_COUNT-1:0]       irq_status;
  logic [`EV_COUNT-1:0]       next_irq_status;
  logic [`EV_COUNT-1:0]       irq_mask;
  logic [`EV_COUNT-1:0]       next_irq_mask;
  logic [`EV_COUNT-1:0]       events;
  logic [7:0]                 next_reg_rdata;
  logic                       next_irq;
  logic [3:0]                 hold_cnt;
  logic [3:0]                 next_hold_cnt;
  logic                       hold_done;
  logic                       tick;
  logic                       tick_run;
  logic                       bus_busy;
  logic                       next_bus_busy;
  logic                       start_seen;
  logic                       stop_seen;
  logic                       drive_scl;
  logic                       drive_sda;
  logic                       module_on;
  logic                       irq_allow;
  logic                       master_select;
  logic                       master_select_prev;
  logic                       next_master_select_prev;
  logic                       select_rose;
  logic                       start_pending;
  logic                       next_start_pending;

  assign module_on     = control_one[`BIT_MODULE_ON];
  assign irq_allow     = control_one[`BIT_IRQ_ALLOW];
  assign master_select = control_one[`BIT_MASTER_SELECT];
  assign line_raw      = '{scl: scl_in, sda: sda_in};

  // only a 0 to 1 change of the master bit asks for a start; a request
  // made during a stop waits here until the sequencer is back in slave
  assign select_rose = master_select && !master_select_prev;

  always_comb begin
    next_master_select_prev = master_select;
    next_start_pending      = start_pending;
    if (!module_on || !master_select) begin
      next_start_pending = 1'b0;
    end else if (select_rose) begin
      next_start_pending = 1'b1;
    end else if (state == i2c_ctrl_pkg::ST_WAIT_FREE) begin
      next_start_pending = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      master_select_prev <= 1'b0;
      start_pending      <= 1'b0;
    end else begin
      master_select_prev <= next_master_select_prev;
      start_pending      <= next_start_pending;
    end
  end

  // pins arrive from outside the clock domain
  i2c_line_sync u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .raw      (line_raw),
    .synced   (line)
  );

  // stop-phase count waits for scl high, so a stretching slave is honoured
  assign tick_run = is_timed(state) && (next_state == state) &&
                    ((state != i2c_ctrl_pkg::ST_STOP_SCL) || line.scl);

  i2c_tick_div u_tick (
    .core_clk (core_clk),
    .resetn   (resetn),
    .run      (tick_run),
    .tick     (tick)
  );

  assign hold_done = (hold_cnt == 4'(`HOLD_TICKS));

  // bus condition watch on synchronised lines
  assign start_seen = line_prev.sda && !line.sda && line.scl && line_prev.scl;
  assign stop_seen  = !line_prev.sda && line.sda && line.scl && line_prev.scl;

  always_comb begin
    next_line_prev = line;
    next_bus_busy  = bus_busy;
    if (!module_on) begin
      next_bus_busy = 1'b0;
    end else if (start_seen) begin
      next_bus_busy = 1'b1;
    end else if (stop_seen) begin
      next_bus_busy = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      line_prev <= '{scl: 1'b1, sda: 1'b1};
      bus_busy  <= 1'b0;
    end else begin
      line_prev <= next_line_prev;
      bus_busy  <= next_bus_busy;
    end
  end

  // start/stop sequencer and hold timer
  always_comb begin
    next_state    = state;
    next_hold_cnt = hold_cnt;
    drive_scl     = 1'b0;
    drive_sda     = 1'b0;
    events        = `EVENT_RESET;
    case (state)
      i2c_ctrl_pkg::ST_SLAVE: begin
        if (module_on && (select_rose || start_pending)) begin
          next_state = i2c_ctrl_pkg::ST_WAIT_FREE;
        end
      end
      i2c_ctrl_pkg::ST_WAIT_FREE: begin
        // never start over someone else's transfer
        if (!master_select) begin
          next_state = i2c_ctrl_pkg::ST_SLAVE;
        end else if (line.scl && line.sda && !bus_busy) begin
          next_state = i2c_ctrl_pkg::ST_START_SDA;
        end
      end
      i2c_ctrl_pkg::ST_START_SDA: begin
        drive_sda = 1'b1;
        if (hold_done) begin
          next_state = i2c_ctrl_pkg::ST_START_SCL;
        end
      end
      i2c_ctrl_pkg::ST_START_SCL: begin
        drive_sda = 1'b1;
        drive_scl = 1'b1;
        if (hold_done) begin
          next_state                = i2c_ctrl_pkg::ST_MASTER;
          events[`EV_START_DONE]    = 1'b1;
        end
      end
      i2c_ctrl_pkg::ST_MASTER: begin
        // clock held low: no data engine here, the bus waits on us
        drive_sda = 1'b1;
        drive_scl = 1'b1;
        if (!master_select) begin
          next_state = i2c_ctrl_pkg::ST_STOP_SDA;
        end
      end
      i2c_ctrl_pkg::ST_STOP_SDA: begin
        drive_sda = 1'b1;
        drive_scl = 1'b1;
        if (hold_done) begin
          next_state = i2c_ctrl_pkg::ST_STOP_SCL;
        end
      end
      i2c_ctrl_pkg::ST_STOP_SCL: begin
        drive_sda = 1'b1; // scl released, sda still low
        if (hold_done) begin
          next_state = i2c_ctrl_pkg::ST_STOP_REL;
        end
      end
      i2c_ctrl_pkg::ST_STOP_REL: begin
        next_state             = i2c_ctrl_pkg::ST_SLAVE;
        events[`EV_STOP_DONE]  = 1'b1;
      end
      default: begin
        next_state = i2c_ctrl_pkg::ST_SLAVE;
      end
    endcase
    if (next_state != state) begin
      next_hold_cnt = 4'h0;
    end else if (tick && !hold_done) begin
      next_hold_cnt = hold_cnt + 4'h1;
    end
    // disabling drops the bus at once, even mid transfer
    if (!module_on) begin
      next_state    = i2c_ctrl_pkg::ST_SLAVE;
      next_hold_cnt = 4'h0;
      drive_scl     = 1'b0;
      drive_sda     = 1'b0;
      events        = `EVENT_RESET;
    end else begin
      events[`EV_START_SEEN] = start_seen;
      events[`EV_STOP_SEEN]  = stop_seen;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state         <= i2c_ctrl_pkg::ST_SLAVE;
      hold_cnt      <= 4'h0;
      scl_oe        <= 1'b0;
      sda_oe        <= 1'b0;
      scl_out       <= 1'b0;
      sda_out       <= 1'b0;
      master_active <= 1'b0;
    end else begin
      state         <= next_state;
      hold_cnt      <= next_hold_cnt;
      scl_oe        <= drive_scl;
      sda_oe        <= drive_sda;
      scl_out       <= 1'b0; // open drain: only ever pulls low
      sda_out       <= 1'b0;
      master_active <= (next_state == i2c_ctrl_pkg::ST_MASTER);
    end
  end

  // register file, status set wins over a same-cycle clear
  always_comb begin
    next_control_one = control_one;
    next_irq_mask    = irq_mask;
    next_irq_status  = irq_status;
    next_reg_rdata   = `BYTE_ZERO;
    if (reg_write && addr_is(reg_addr, `REG_CONTROL_ONE)) begin
      next_control_one = reg_wdata & `CONTROL_ONE_WMASK;
    end
    if (reg_write && addr_is(reg_addr, `REG_IRQ_MASK)) begin
      next_irq_mask = reg_wdata[`EV_COUNT-1:0];
    end
    if (reg_write && addr_is(reg_addr, `REG_IRQ_STATUS)) begin
      next_irq_status = irq_status & ~reg_wdata[`EV_COUNT-1:0];
    end
    next_irq_status = next_irq_status | events;
    if (reg_read) begin
      if (addr_is(reg_addr, `REG_CONTROL_ONE)) begin
        next_reg_rdata = control_one;
      end else if (addr_is(reg_addr, `REG_IRQ_STATUS)) begin
        next_reg_rdata = {4'h0, irq_status};
      end else if (addr_is(reg_addr, `REG_IRQ_MASK)) begin
        next_reg_rdata = {4'h0, irq_mask};
      end else if (addr_is(reg_addr, `REG_LINE_STATUS)) begin
        next_reg_rdata = {4'h0, bus_busy, (state == i2c_ctrl_pkg::ST_MASTER), line.scl, line.sda};
      end
    end
    next_irq = module_on && irq_allow && |(irq_status & irq_mask);
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      control_one  <= `CONTROL_ONE_RESET;
      irq_mask     <= `EVENT_RESET;
      irq_status   <= `EVENT_RESET;
      reg_rdata    <= `BYTE_ZERO;
      irq          <= 1'b0;
      transmit_dir <= 1'b0;
    end else begin
      control_one  <= next_control_one;
      irq_mask     <= next_irq_mask;
      irq_status   <= next_irq_status;
      reg_rdata    <= next_reg_rdata;
      irq          <= next_irq;
      transmit_dir <= next_control_one[`BIT_TX_SELECT];
    end
  end

endmodule : i2c_control_one_master_start_stop

// ==== i2c_ctrl_cfg.svh ====
/*
  named constants of the two-wire bus control block: register offsets,
  control bit positions, reset values, event bits and timing counts.
  assumes a 100 MHz core clock and byte-wide register port.
*/
`ifndef I2C_CTRL_CFG_SVH
`define I2C_CTRL_CFG_SVH

// register offsets on the plain register port
`define REG_CONTROL_ONE   8'h02
`define REG_IRQ_STATUS    8'h04
`define REG_IRQ_MASK      8'h05
`define REG_LINE_STATUS   8'h06

// control one bit positions
`define BIT_MODULE_ON     7
`define BIT_IRQ_ALLOW     6
`define BIT_MASTER_SELECT 5
`define BIT_TX_SELECT     4

// reset values and writable bits
`define CONTROL_ONE_RESET 8'h00
`define CONTROL_ONE_WMASK 8'hf0
`define EVENT_RESET       4'h0
`define BYTE_ZERO         8'h00

// event bits of status and mask
`define EV_COUNT          4
`define EV_START_DONE     0
`define EV_STOP_DONE      1
`define EV_START_SEEN     2
`define EV_STOP_SEEN      3

// timing: clock rate, divider tick and condition hold time
`define CLK_MHZ           100
`define TICK_NS           1000
`define TICK_CYCLES       ((`TICK_NS * `CLK_MHZ) / 1000)
`define HOLD_TIME_NS      5000
`define HOLD_TICKS        ((`HOLD_TIME_NS + `TICK_NS - 1) / `TICK_NS)

`endif

// ==== i2c_ctrl_pkg.sv ====
/*
  types of the two-wire bus control block: line pair carrier and the
  one-hot states of the start/stop sequencer.
  assumes nothing beyond a systemverilog compiler.
*/
package i2c_ctrl_pkg;

  // clock and data line levels travel together
  typedef struct packed {
    logic scl;
    logic sda;
  } line_pair_t;

  // start/stop sequencer, one-hot
  typedef enum logic [7:0] {
    ST_SLAVE     = 8'h01,
    ST_WAIT_FREE = 8'h02,
    ST_START_SDA = 8'h04,
    ST_START_SCL = 8'h08,
    ST_MASTER    = 8'h10,
    ST_STOP_SDA  = 8'h20,
    ST_STOP_SCL  = 8'h40,
    ST_STOP_REL  = 8'h80
  } seq_state_t;

endpackage : i2c_ctrl_pkg

// ==== i2c_line_sync.sv ====
/*
  two-stage synchroniser for the sampled bus lines.
  assumes raw lines come from pins outside the core clock domain.
*/
`timescale 1ns/1ps
module i2c_line_sync (
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  input  wire i2c_ctrl_pkg::line_pair_t raw,
  output      i2c_ctrl_pkg::line_pair_t synced
);

  i2c_ctrl_pkg::line_pair_t stage_one;
  i2c_ctrl_pkg::line_pair_t next_stage_one;
  i2c_ctrl_pkg::line_pair_t next_synced;

  // stage one feeds only stage two; idle bus is high
  always_comb begin
    next_stage_one = raw;
    next_synced    = stage_one;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stage_one <= '{scl: 1'b1, sda: 1'b1};
      synced    <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      stage_one <= next_stage_one;
      synced    <= next_synced;
    end
  end

endmodule : i2c_line_sync

// ==== i2c_tick_div.sv ====
/*
  divider giving a one-cycle enable every tick period while run is high.
  assumes run drops between timed phases so each phase starts in step.
*/
`timescale 1ns/1ps
`include "i2c_ctrl_cfg.svh"
module i2c_tick_div (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic run,
  output      logic tick
);

  logic [6:0] count;
  logic [6:0] next_count;
  logic       next_tick;

  // restart on every phase so hold times never come up short
  always_comb begin
    next_count = count;
    next_tick  = 1'b0;
    if (!run) begin
      next_count = 7'h00;
    end else if (count == 7'(`TICK_CYCLES - 1)) begin
      next_count = 7'h00;
      next_tick  = 1'b1;
    end else begin
      next_count = count + 7'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      count <= 7'h00;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

endmodule : i2c_tick_div

// ==== i2c_ctrl_sva.sv ====
/*
  checker of the bus control block ports: register reads, direction copy,
  enable gating and the start/stop line order and timing.
  assumes byte register port on core_clk and the package constants.
*/
`timescale 1ns/1ps
`include "i2c_ctrl_cfg.svh"
module i2c_ctrl_sva (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       transmit_dir,
  input wire logic       master_active
);
  logic [7:0]  ctl;
  logic [7:0]  next_ctl;
  logic [11:0] sda_lead;
  logic [11:0] next_sda_lead;

  // shadow of control one; lead counter saturates so it never wraps
  always_comb begin
    next_ctl = ctl;
    if (reg_write && reg_addr == `REG_CONTROL_ONE) begin
      next_ctl = reg_wdata & `CONTROL_ONE_WMASK;
    end
    next_sda_lead = 12'h000;
    if (sda_oe && !scl_oe) begin
      next_sda_lead = (sda_lead == 12'hfff) ? sda_lead : sda_lead + 12'h001;
    end
  end

  // registers only
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctl      <= `CONTROL_ONE_RESET;
      sda_lead <= 12'h000;
    end else begin
      ctl      <= next_ctl;
      sda_lead <= next_sda_lead;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_start_edge;
    $rose(scl_oe) && sda_oe;
  endsequence

  a_rdata_idle_zero: assert property (!reg_read |=> reg_rdata == `BYTE_ZERO)
    else $error("read data not zero outside read answer");
  a_ctl_read_back: assert property (reg_read && reg_addr == `REG_CONTROL_ONE
    |=> reg_rdata == $past(ctl))
    else $error("control one read back wrong");
  a_dir_copy_bit: assert property ($stable(ctl[4]) |-> transmit_dir == ctl[4])
    else $error("direction output differs from control bit");
  a_off_lines_free: assert property (!ctl[7] |=> !scl_oe && !sda_oe && !master_active)
    else $error("lines driven while module off");
  a_irq_needs_allow: assert property (!(ctl[7] && ctl[6]) |=> !irq)
    else $error("interrupt raised while not allowed");
  a_start_sda_first: assert property ($rose(scl_oe) |-> sda_oe)
    else $error("clock pulled before data at start");
  a_start_hold_time: assert property ($rose(scl_oe) |-> sda_lead inside {[490:620]})
    else $error("start hold time out of range");
  a_master_after_start: assert property (s_start_edge |-> ##[1:700] master_active)
    else $error("master state not reached after start");
  a_master_needs_sel: assert property ($rose(master_active) |-> ctl[5] && ctl[7])
    else $error("master state without master select");
  a_stop_scl_first: assert property ($fell(scl_oe) && ctl[7] |-> sda_oe)
    else $error("data released before clock at stop");
  a_drive_only_low: assert property (!scl_out && !sda_out)
    else $error("line output not low");
endmodule : i2c_ctrl_sva

bind i2c_control_one_master_start_stop i2c_ctrl_sva i2c_ctrl_sva_inst (
  .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
  .transmit_dir(transmit_dir), .master_active(master_active)
);

// ==== bus_peer.sv ====
/*
  other bus party: pull-ups, wired-and lines, clock stretching and a
  foreign start/stop frame clocked at 160 ns.
  assumes the device pulls a line low while its enable is high.
*/
`timescale 1ns/1ps
module bus_peer (
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output      logic scl_in,
  output      logic sda_in
);
  logic scl_drv;
  logic sda_drv;
  logic stretch;

  // released lines float high through the pull-ups
  assign scl_in = !(scl_oe || scl_drv);
  assign sda_in = !(sda_oe || sda_drv);

  initial begin
    scl_drv = 1'b0;
    sda_drv = 1'b0;
    stretch = 1'b0;
  end

  // a slow slave holds the clock low after the device lets it go
  always @(negedge scl_oe) begin
    if (stretch) begin
      scl_drv = 1'b1;
      #2000 scl_drv = 1'b0;
    end
  end

  // start, four clock pulses, stop; clock stands still outside the frame
  task frame;
    #400 sda_drv = 1'b1;
    #800 scl_drv = 1'b1;
    repeat (4) begin
      #80 scl_drv = 1'b0;
      #80 scl_drv = 1'b1;
    end
    #80 scl_drv = 1'b0;
    #800 sda_drv = 1'b0;
    #400;
  endtask : frame
endmodule : bus_peer

// ==== tb_i2c_control_one_master_start_stop.sv ====
/*
  self-checking bench of the bus control block: register port, start and
  stop on the lines, interrupt gating, foreign bus conditions.
  assumes the bound checker and the bus peer model.
*/
`timescale 1ns/1ps
`include "i2c_ctrl_cfg.svh"
module tb_i2c_control_one_master_start_stop;
  logic        core_clk, resetn, reg_write, reg_read, irq;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
  logic        scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
  logic        transmit_dir, master_active;
  logic [15:0] lfsr;
  int          fail_count, tests_run, cycles, i;

  i2c_control_one_master_start_stop i2c_control_one_master_start_stop_inst (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .transmit_dir(transmit_dir),
    .master_active(master_active));
  bus_peer bus_peer_inst (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    lfsr_step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step
  // only the top nibble of control one is kept
  function automatic logic [7:0] ctl_expect(input logic [7:0] w);
    ctl_expect = w & 8'hf0;
  endfunction : ctl_expect

  task wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd
  // bounded wait: 0 waits on master state, 1 on data enable
  task wait_for(input int which, input logic want);
    int n;
    n = 0;
    while ((which == 0 ? master_active : sda_oe) !== want && n < 4000) begin
      idle(1);
      n++;
    end
    chk({7'h00, (which == 0 ? master_active : sda_oe)}, {7'h00, want});
  endtask : wait_for

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // hang guard well above the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      $display("Error at %0t: run too long", $time);
      wrap_up();
    end
  end

  initial begin
    {resetn, reg_write, reg_read, reg_addr, reg_wdata} = '0;
    lfsr = 16'h3dab;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    rd(`REG_CONTROL_ONE, `CONTROL_ONE_RESET);
    rd(`REG_IRQ_STATUS, `BYTE_ZERO);
    rd(`REG_IRQ_MASK, `BYTE_ZERO);
    wr(8'h40, 8'hff);
    rd(8'h40, `BYTE_ZERO);
    // direction and readback with the module off
    for (i = 0; i < 6; i++) begin
      lfsr = lfsr_step(lfsr);
      v = (i == 0) ? 8'h5f : (i == 1) ? 8'h00 : lfsr[7:0] & 8'h5f;
      wr(`REG_CONTROL_ONE, v);
      rd(`REG_CONTROL_ONE, ctl_expect(v));
      chk({7'h00, transmit_dir}, {7'h00, v[4]});
    end
    // master select while off makes no start
    wr(`REG_CONTROL_ONE, 8'h20);
    idle(1200);
    chk({6'h00, sda_oe, master_active}, 8'h00);
    wr(`REG_CONTROL_ONE, 8'h00);
    // start with interrupts held back
    wr(`REG_IRQ_MASK, 8'h0f);
    wr(`REG_CONTROL_ONE, 8'hb0);
    wait_for(0, 1'b1);
    chk({4'h0, scl_out, sda_out, scl_oe, sda_oe}, 8'h03);
    rd(`REG_LINE_STATUS, 8'h0c);
    rd(`REG_IRQ_STATUS, 8'h05);
    chk({7'h00, irq}, 8'h00);
    wr(`REG_CONTROL_ONE, 8'hf0);
    idle(3);
    chk({7'h00, irq}, 8'h01);
    wr(`REG_IRQ_STATUS, 8'h05);
    idle(3);
    chk({7'h00, irq}, 8'h00);
    // stop against a stretching slave
    bus_peer_inst.stretch = 1'b1;
    wr(`REG_CONTROL_ONE, 8'hc0);
    wait_for(1, 1'b0);
    bus_peer_inst.stretch = 1'b0;
    idle(3);
    chk({5'h00, master_active, scl_in, sda_in}, 8'h03);
    rd(`REG_LINE_STATUS, 8'h03);
    rd(`REG_IRQ_STATUS, 8'h0a);
    wr(`REG_IRQ_STATUS, 8'h0a);
    // foreign frame, unmasked then masked
    bus_peer_inst.frame();
    idle(10);
    chk({7'h00, irq}, 8'h01);
    wr(`REG_IRQ_STATUS, 8'h0c);
    wr(`REG_IRQ_MASK, 8'h00);
    bus_peer_inst.frame();
    idle(10);
    rd(`REG_IRQ_STATUS, 8'h0c);
    chk({7'h00, irq}, 8'h00);
    // switching off in master state frees both lines at once
    wr(`REG_CONTROL_ONE, 8'ha0);
    wait_for(0, 1'b1);
    wr(`REG_CONTROL_ONE, 8'h20);
    idle(2);
    chk({5'h00, scl_oe, sda_oe, master_active}, 8'h00);
    rd(`REG_CONTROL_ONE, 8'h20);
    // mid-run reset brings control one and direction back to reset
    wr(`REG_CONTROL_ONE, 8'hd0);
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    rd(`REG_CONTROL_ONE, `CONTROL_ONE_RESET);
    chk({7'h00, transmit_dir}, 8'h00);
    wrap_up();
  end
endmodule : tb_i2c_control_one_master_start_stop
